// >>> bench/rcesel_credit_model.sv
// model of the credit trackers and queue status feeding the event inputs
`timescale 1ns/10ps
module rcesel_credit_model
(
   input wire logic clock,
   input wire logic active,
   output logic [50:0] status
);
   integer seed = 32'hB28C;
   logic [63:0] r;
   // sparse random conditions, all quiet outside the active window
   always @(posedge clock)
   begin
      r = {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
      status <= active ? r[50:0] : 51'h0;
   end
endmodule

// >>> bench/rcesel_top_assertions.sv
// concurrent checks on the bus and overflow ports of the event block
`timescale 1ns/10ps
module rcesel_top_checker
   import rcesel_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [rcesel_pkg::rcesel_addr_width-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic global_freeze,
   input wire logic overflow_message
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic rd_done;
   assign rd_done = avs_read && !avs_waitrequest;
   a_answer_time: assert property ($rose(avs_read || avs_write)
      |=> !avs_waitrequest) else $error("request not answered in time");
   a_wait_low_once: assert property (!avs_waitrequest
      |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_unmapped_zero: assert property (rd_done && avs_address > 4'hA
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_ctl_bits: assert property (rd_done && avs_address % 3 == 0
      && avs_address < 4'h9 |-> (avs_readdata & ~ctl_write_mask) == 32'h0)
      else $error("control readback has unused bits set");
   a_ctr_high_width: assert property (rd_done && avs_address % 3 == 2
      && avs_address < 4'h9 |-> avs_readdata[31:12] == 20'h0)
      else $error("counter high word wider than 12 bits");
   a_status_bits: assert property (rd_done && avs_address == 4'h9
      |-> avs_readdata[31:3] == 29'h0) else $error("status has extra bits");
   a_ovf_pulse: assert property (overflow_message |=> !overflow_message)
      else $error("overflow message longer than one cycle");
   a_freeze_quiet: assert property (global_freeze [*5]
      |-> !overflow_message) else $error("overflow while frozen");
endmodule

bind rcesel_top rcesel_top_checker i_checker (.clock(clock), .reset(reset),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .global_freeze(global_freeze), .overflow_message(overflow_message));

// >>> bench/test_ring_credit_event_select.sv
// self-checking bench for the credit event selection block
`timescale 1ns/10ps
module test_ring_credit_event_select;
   import rcesel_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic global_freeze = 1'b0;
   logic active = 1'b0;
   logic [50:0] st;
   logic overflow_message;
   int errors = 0;
   int num_checks = 0;
   integer seed = 32'hB28C;
   logic [31:0] rdata;
   int n;
   logic [7:0] codes [11] = '{ev_port0_addr, ev_port1_addr, ev_lower_agent,
      ev_upper_agent, ev_port0_data, ev_port1_data, ev_home_bridge,
      ev_pool_out, ev_pool_inuse, ev_net0_fail, ev_net1_fail};
   logic [3:0] ra [4] = '{4'h0, 4'hA, 4'h1, 4'hF};
   logic [31:0] rv [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
   always #10 clock = ~clock;
   rcesel_credit_model i_model (.clock(clock), .active(active), .status(st));
   rcesel_top i_dut (.clock(clock), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .global_freeze(global_freeze),
      .upper_agent_addr_credit_empty(st[6:0]),
      .lower_agent_addr_credit_empty(st[14:7]),
      .home_bridge_data_credit_empty(st[18:15]),
      .port0_addr_credit_empty(st[25:19]),
      .port0_data_credit_empty(st[32:26]),
      .port1_addr_credit_empty(st[39:33]),
      .port1_data_credit_empty(st[46:40]),
      .shared_pool_out_cycles(st[47]), .shared_pool_inuse_cycles(st[48]),
      .net0_acquire_fail(st[49]), .net1_acquire_fail(st[50]),
      .overflow_message(overflow_message));
   task automatic finish_test;
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_near(input logic [31:0] got, input int exp,
      input int tol);
      num_checks++;
      if ($isunknown(got) || got < exp - tol || got > exp + tol)
      begin
         errors++;
         $display("FAIL %0t count %0d expected about %0d", $time, got, exp);
      end
   endtask
   // one Avalon cycle, held until waitrequest is sampled low
   task automatic bus(input bit wr, input int a, input logic [31:0] d);
      avs_address <= 4'(a);
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0)
         @(posedge clock);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   function automatic bit hit(input logic [7:0] c, input logic [7:0] m);
      case (c)
         ev_upper_agent: return |(m[6:0] & st[6:0]);
         ev_lower_agent: return |(m & st[14:7]);
         ev_home_bridge: return |(m[3:0] & st[18:15]);
         ev_port0_addr: return |(m[6:0] & st[25:19]);
         ev_port0_data: return |(m[6:0] & st[32:26]);
         ev_port1_addr: return |(m[6:0] & st[39:33]);
         ev_port1_data: return |(m[6:0] & st[46:40]);
         ev_pool_out: return st[47];
         ev_pool_inuse: return st[48];
         ev_net0_fail: return st[49];
         ev_net1_fail: return st[50];
         default: return 1'b0;
      endcase
   endfunction
   // program, clear, feed a burst of conditions, read back the count
   task automatic run_ev(input logic [7:0] c, input int ctr, input bit ok);
      logic [7:0] m;
      int cnt;
      m = 8'($random(seed)) | 8'h01;
      cnt = 0;
      bus(1, 3 * ctr, 32'h0042_0000 | {16'h0, m, c});
      active <= 1'b1;
      for (int k = 0; k < 44; k++)
      begin
         @(posedge clock);
         cnt += hit(c, m);
         active <= (k < 39);
      end
      bus(0, 3 * ctr + 1, 32'h0);
      check(rdata, ok ? 32'(cnt) : 32'h0);
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      check(32'h1, 32'h0);
      finish_test;
   end
   initial
   begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      foreach (ra[i])
      begin
         bus(0, ra[i], 32'h0);
         check(rdata, rv[i]);
      end
      bus(1, 10, 32'h0);
      bus(0, 10, 32'h0);
      check(rdata, 32'h0);
      bus(1, 10, 32'h1);
      bus(1, 15, 32'hFFFF_FFFF);
      bus(1, 0, 32'hFFFF_FFFF);
      bus(0, 0, 32'h0);
      check(rdata, ctl_write_mask);
      for (int j = 0; j < 2; j++)
         foreach (codes[i])
            run_ev(codes[i], (i + j) % 2, 1'b1);
      run_ev(ev_home_bridge, 2, 1'b0);
      global_freeze <= 1'b1;
      bus(1, 6, 32'h0042_0001);
      global_freeze <= 1'b0;
      repeat (100) @(posedge clock);
      global_freeze <= 1'b1;
      repeat (4) @(posedge clock);
      bus(0, 7, 32'h0);
      check_near(rdata, 100, 2);
      bus(1, 0, 32'h0050_0001);
      bus(1, 2, 32'h0000_0FFF);
      bus(1, 1, 32'hFFFF_FFF0);
      global_freeze <= 1'b0;
      for (n = 0; n < 60 && overflow_message !== 1'b1; n++)
         @(posedge clock);
      check_near(n, 19, 3);
      global_freeze <= 1'b1;
      bus(0, 9, 32'h0);
      check(rdata & 32'h7, 32'h1);
      bus(0, 2, 32'h0);
      check(rdata, 32'h0);
      bus(1, 9, 32'h1);
      bus(0, 9, 32'h0);
      check(rdata & 32'h7, 32'h0);
      finish_test;
   end
endmodule

// >>> rtl/rcesel_counter.sv
// one 44-bit event counter with software load and clear
`timescale 1ns/10ps
module rcesel_counter
   import rcesel_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   rcesel_ctr_if.slice ctr
);
   logic [rcesel_ctr_width:0] sum;
   assign sum = {1'b0, ctr.value} + {{rcesel_ctr_width{1'b0}}, 1'b1};
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ctr.value <= '0;
      else if (ctr.clear)
         ctr.value <= '0;
      else if (ctr.load_lo)
         ctr.value[31:0] <= ctr.load_data;
      else if (ctr.load_hi)
         ctr.value[43:32] <= ctr.load_data[11:0];
      else if (ctr.count_en)
         ctr.value <= sum[rcesel_ctr_width-1:0]; // wraps
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ctr.carry_out <= 1'b0;
      else
         ctr.carry_out <= ctr.count_en && !ctr.clear && !ctr.load_lo &&
            !ctr.load_hi && sum[rcesel_ctr_width];
   end
endmodule

// >>> rtl/rcesel_event_mux.sv
// selects and combines one counter's event condition from the inputs
`timescale 1ns/10ps
module rcesel_event_mux
   import rcesel_pkg::*;
#(
   parameter int ctr_index = 0
)
(
   input wire logic [7:0] event_code_field,
   input wire logic [7:0] sub_mask,
   input wire logic [6:0] upper_agent_addr_credit_empty,
   input wire logic [7:0] lower_agent_addr_credit_empty,
   input wire logic [3:0] home_bridge_data_credit_empty,
   input wire logic [6:0] port0_addr_credit_empty,
   input wire logic [6:0] port0_data_credit_empty,
   input wire logic [6:0] port1_addr_credit_empty,
   input wire logic [6:0] port1_data_credit_empty,
   input wire logic shared_pool_out_cycles,
   input wire logic shared_pool_inuse_cycles,
   input wire logic net0_acquire_fail,
   input wire logic net1_acquire_fail,
   output logic hit
);
   always_comb
   begin
      // any selected sub-condition makes the event active
      case (event_code_field)
         ev_uncore_tick: hit = 1'b1;
         ev_upper_agent:
            hit = |(sub_mask[6:0] & upper_agent_addr_credit_empty);
         ev_lower_agent:
            hit = |(sub_mask & lower_agent_addr_credit_empty);
         ev_home_bridge:
            hit = (ctr_index < 2) &&
               |(sub_mask[3:0] & home_bridge_data_credit_empty);
         ev_port0_addr:
            hit = |(sub_mask[6:0] & port0_addr_credit_empty);
         ev_port0_data:
            hit = |(sub_mask[6:0] & port0_data_credit_empty);
         ev_port1_addr:
            hit = |(sub_mask[6:0] & port1_addr_credit_empty);
         ev_port1_data:
            hit = |(sub_mask[6:0] & port1_data_credit_empty);
         ev_pool_out: hit = (ctr_index < 2) && shared_pool_out_cycles;
         ev_pool_inuse:
            hit = (ctr_index < 2) && shared_pool_inuse_cycles;
         ev_net0_fail: hit = (ctr_index < 2) && net0_acquire_fail;
         ev_net1_fail: hit = (ctr_index < 2) && net1_acquire_fail;
         default: hit = 1'b0;
      endcase
   end
endmodule

// >>> rtl/rcesel_top.sv
// credit event selection and counters with Avalon-MM register access
// Behaviour
// - tick event 0x01 counts every uncore cycle, on any of counters 0-2.
// - local tick count stays within a few cycles of the global count.
// - code 0x2c counts no address credit to upper agents; mask bits 0-6.
// - code 0x2b counts no address credit to lower agents 0-7 by mask bit.
// - code 0x2f: no data credit to home agents 0,1 or bridge classes.
// - for 0x2f, counter 0 lower agents, counter 1 higher agents; here counters 0 and 1 both see the same four inputs.
// - code 0x29: no address credit to port 0, pool plus six classes.
// - code 0x2d: no data credit to port 0, same seven-bit mask.
// - code 0x2a: no address credit to port 1, same seven-bit mask.
// - code 0x2e: no data credit to port 1, same seven-bit mask.
// - code 0x31 counts cycles with no shared-pool credit; counters 0-1.
// - code 0x32 counts cycles with a pool credit in use; counters 0-1.
// - codes 0x37, 0x39 count failed data-response acquires, nets 0, 1.
// - control bits 15:8 pick sub-conditions, bits 7:0 pick the event.
// - counters are 44 bits; carry out of bit 43 flags overflow.
`timescale 1ns/10ps
module rcesel_top
   import rcesel_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [rcesel_pkg::rcesel_addr_width-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic global_freeze,
   input wire logic [6:0] upper_agent_addr_credit_empty,
   input wire logic [7:0] lower_agent_addr_credit_empty,
   input wire logic [3:0] home_bridge_data_credit_empty,
   input wire logic [6:0] port0_addr_credit_empty,
   input wire logic [6:0] port0_data_credit_empty,
   input wire logic [6:0] port1_addr_credit_empty,
   input wire logic [6:0] port1_data_credit_empty,
   input wire logic shared_pool_out_cycles,
   input wire logic shared_pool_inuse_cycles,
   input wire logic net0_acquire_fail,
   input wire logic net1_acquire_fail,
   output logic overflow_message
);
   import rcesel_pkg::*;

   logic [31:0] ctl [rcesel_num_ctrs];
   logic [rcesel_num_ctrs-1:0] ovf_status;
   logic global_enable;
   logic frozen;
   logic [rcesel_num_ctrs-1:0] hit;
   logic [rcesel_num_ctrs-1:0] ovf_event;
   logic [31:0] wmask;
   logic [31:0] next_readdata;
   rcesel_bus_state_type bus_state;
   logic req;

   assign req = avs_read || avs_write;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   // one wait cycle: answer on the second cycle of a request
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         bus_state <= rcesel_idle_type;
      else
         case (bus_state)
            rcesel_idle_type:
               if (req)
                  bus_state <= rcesel_ans_type;
            rcesel_ans_type: bus_state <= rcesel_idle_type;
            default: bus_state <= rcesel_idle_type;
         endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !(bus_state == rcesel_idle_type && req);
   end

   // write lands at the edge where the master sees waitrequest low
   logic wr_take;
   assign wr_take = avs_write && bus_state == rcesel_ans_type;

   // freeze gates all counting uniformly; small lag against global
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         frozen <= 1'b0;
      else
         frozen <= global_freeze;
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         global_enable <= global_reset_value[0];
      else if (wr_take && avs_address == reg_global && avs_byteenable[0])
         global_enable <= avs_writedata[0];
   end

   genvar g;
   generate
      for (g = 0; g < rcesel_num_ctrs; g++)
      begin : slot
         rcesel_ctr_if cif();
         logic [3:0] base;
         assign base = 4'(reg_ctl0 + 4'(g * reg_stride));

         always_ff @(posedge clock or posedge reset)
         begin
            if (reset)
               ctl[g] <= ctl_reset_value;
            else if (wr_take && avs_address == base)
               ctl[g] <= (ctl[g] & ~(wmask & ctl_write_mask)) |
                  (avs_writedata & wmask & ctl_write_mask);
         end

         // event code bits 7:0, sub-event mask bits 15:8
         rcesel_event_mux #(.ctr_index(g)) emux (
            .event_code_field(ctl[g][ctl_code_lsb +: 8]),
            .sub_mask(ctl[g][ctl_mask_lsb +: 8]),
            .upper_agent_addr_credit_empty(upper_agent_addr_credit_empty),
            .lower_agent_addr_credit_empty(lower_agent_addr_credit_empty),
            .home_bridge_data_credit_empty(home_bridge_data_credit_empty),
            .port0_addr_credit_empty(port0_addr_credit_empty),
            .port0_data_credit_empty(port0_data_credit_empty),
            .port1_addr_credit_empty(port1_addr_credit_empty),
            .port1_data_credit_empty(port1_data_credit_empty),
            .shared_pool_out_cycles(shared_pool_out_cycles),
            .shared_pool_inuse_cycles(shared_pool_inuse_cycles),
            .net0_acquire_fail(net0_acquire_fail),
            .net1_acquire_fail(net1_acquire_fail),
            .hit(hit[g])
         );

         // the bridge inputs are not split: counters 0 and 1 both see the same
         // four bits, and counter 2 never counts them
         assign cif.count_en = hit[g] && ctl[g][ctl_enable_bit] &&
            global_enable && !frozen;
         assign cif.clear = wr_take && avs_address == base &&
            avs_byteenable[2] && avs_writedata[ctl_clear_bit];
         assign cif.load_lo = wr_take && avs_address == 4'(base + 4'h1) &&
            (&avs_byteenable);
         assign cif.load_hi = wr_take && avs_address == 4'(base + 4'h2) &&
            (&avs_byteenable[1:0]);
         assign cif.load_data = avs_writedata;
         assign ovf_event[g] = cif.carry_out && ctl[g][ctl_ovf_en_bit];

         rcesel_counter cnt (
            .clock(clock),
            .reset(reset),
            .ctr(cif)
         );

         logic [31:0] rd_lo;
         logic [31:0] rd_hi;
         assign rd_lo = cif.value[31:0];
         assign rd_hi = {20'h0_0000, cif.value[43:32]};
      end
   endgenerate

   // sticky overflow status; set wins over software clear
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ovf_status <= '0;
      else if (wr_take && avs_address == reg_status && avs_byteenable[0])
         ovf_status <= (ovf_status & ~avs_writedata[2:0]) | ovf_event;
      else
         ovf_status <= ovf_status | ovf_event;
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         overflow_message <= 1'b0;
      else
         overflow_message <= |ovf_event;
   end

   always_comb
   begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         4'h0: next_readdata = ctl[0] & ~(32'h1 << ctl_clear_bit);
         4'h1: next_readdata = slot[0].rd_lo;
         4'h2: next_readdata = slot[0].rd_hi;
         4'h3: next_readdata = ctl[1] & ~(32'h1 << ctl_clear_bit);
         4'h4: next_readdata = slot[1].rd_lo;
         4'h5: next_readdata = slot[1].rd_hi;
         4'h6: next_readdata = ctl[2] & ~(32'h1 << ctl_clear_bit);
         4'h7: next_readdata = slot[2].rd_lo;
         4'h8: next_readdata = slot[2].rd_hi;
         reg_status: next_readdata = {29'h0, ovf_status};
         reg_global: next_readdata = {31'h0, global_enable};
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && bus_state == rcesel_idle_type)
         avs_readdata <= next_readdata;
   end
endmodule

// >>> shared/rcesel_ctr_if.sv
// per counter control and status bundle between top and counter slice
`timescale 1ns/10ps
interface rcesel_ctr_if;
   import rcesel_pkg::*;
   logic count_en;
   logic clear;
   logic load_lo;
   logic load_hi;
   logic [31:0] load_data;
   logic [rcesel_ctr_width-1:0] value;
   logic carry_out;
   modport top (output count_en, clear, load_lo, load_hi, load_data,
      input value, carry_out);
   modport slice (input count_en, clear, load_lo, load_hi, load_data,
      output value, carry_out);
endinterface

// >>> shared/rcesel_pkg.sv
// constants and types shared by the credit event selection block
package rcesel_pkg;
   localparam int rcesel_num_ctrs = 3;
   localparam int rcesel_ctr_width = 44;
   localparam int rcesel_addr_width = 4;
   // event codes
   localparam logic [7:0] ev_uncore_tick = 8'h01;
   localparam logic [7:0] ev_port0_addr = 8'h29;
   localparam logic [7:0] ev_port1_addr = 8'h2A;
   localparam logic [7:0] ev_lower_agent = 8'h2B;
   localparam logic [7:0] ev_upper_agent = 8'h2C;
   localparam logic [7:0] ev_port0_data = 8'h2D;
   localparam logic [7:0] ev_port1_data = 8'h2E;
   localparam logic [7:0] ev_home_bridge = 8'h2F;
   localparam logic [7:0] ev_pool_out = 8'h31;
   localparam logic [7:0] ev_pool_inuse = 8'h32;
   localparam logic [7:0] ev_net0_fail = 8'h37;
   localparam logic [7:0] ev_net1_fail = 8'h39;
   // control word fields
   localparam int ctl_code_lsb = 0;
   localparam int ctl_mask_lsb = 8;
   localparam int ctl_clear_bit = 17;
   localparam int ctl_ovf_en_bit = 20;
   localparam int ctl_enable_bit = 22;
   localparam logic [31:0] ctl_reset_value = 32'h0000_0000;
   localparam logic [31:0] ctl_write_mask = 32'h0050_FFFF;
   // word indices: ctl n at 3n, ctr low at 3n+1, ctr high at 3n+2
   localparam logic [3:0] reg_ctl0 = 4'h0;
   localparam int reg_stride = 3;
   localparam logic [3:0] reg_status = 4'h9;
   localparam logic [3:0] reg_global = 4'hA;
   localparam logic [31:0] global_reset_value = 32'h0000_0001;
   typedef enum logic [1:0] {
      rcesel_idle_type = 2'b00,
      rcesel_ans_type = 2'b01
   } rcesel_bus_state_type;
endpackage
